// ### lacap_pkg.sv
// package: constants and carrier types for the logic analyzer capture core
package lacap_pkg;
   localparam int unsigned N_CH = 18;
   localparam int unsigned N_LVL = 4;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned CNT_W = ADDR_W + 1;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned RATE_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
   localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
   localparam logic [RATE_W-1:0] DIV_RST = 8'h00;

   // per-channel trigger condition
   typedef enum logic [2:0] {
      LACAP_C_ANY = 3'b000,
      LACAP_C_HIGH = 3'b001,
      LACAP_C_LOW = 3'b010,
      LACAP_C_RISE = 3'b011,
      LACAP_C_FALL = 3'b100,
      LACAP_C_EDGE = 3'b101
   } lacap_cond_t;

   // post-trigger amount
   typedef enum logic [2:0] {
      LACAP_P_STOP = 3'b000,
      LACAP_P_FULL = 3'b001,
      LACAP_P_EARLY = 3'b010,
      LACAP_P_CENTER = 3'b011,
      LACAP_P_LATE = 3'b100
   } lacap_post_t;

   typedef enum logic [2:0] {
      LACAP_S_IDLE = 3'b000,
      LACAP_S_ARMED = 3'b001,
      LACAP_S_POST = 3'b010,
      LACAP_S_DUMP = 3'b011,
      LACAP_S_DONE = 3'b100
   } lacap_state_t;

   typedef struct packed {
      logic ext_mode;
      logic ext_falling;
      logic [RATE_W-1:0] rate_div;
      lacap_post_t post;
      logic [1:0] last_level;
      logic auto_mode;
   } lacap_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [N_CH-1:0] data;
   } lacap_word_t;
endpackage : lacap_pkg

// ### lacap_fifo.sv
// file: parameterised valid/ready FIFO for readout words
`timescale 1ns/1ps
`default_nettype none
module lacap_fifo #(
   parameter int unsigned WIDTH = 28,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } lacap_fst_t;
   lacap_fst_t st_r;
   lacap_fst_t st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data = mem[st_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
         st_nxt.wp = st_r.wp + 1'b1;
      if (pop)
         st_nxt.rp = st_r.rp + 1'b1;
      if (push && !pop)
         st_nxt.cnt = st_r.cnt + 1'b1;
      else if (pop && !push)
         st_nxt.cnt = st_r.cnt - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_r <= '0;
      else if (ce)
         st_r <= st_nxt;
      if (ce && push)
         mem[st_r.wp] <= in_data;
   end
endmodule : lacap_fifo
`default_nettype wire

// ### lacap_core.sv
// file: logic analyzer acquisition core with trigger and readout
`timescale 1ns/1ps
`default_nettype none
module lacap_core #(
   parameter int unsigned N_CH = lacap_pkg::N_CH,
   parameter int unsigned ADDR_W = lacap_pkg::ADDR_W,
   parameter int unsigned FIFO_DEPTH = lacap_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [N_CH-1:0] probe_in,
   input wire logic external_sample_clock_input,
   input wire logic clock_qualifier,
   input wire lacap_pkg::lacap_cfg_t cfg,
   input wire logic [lacap_pkg::N_LVL*N_CH*3-1:0] trig_cond,
   input wire logic start,
   input wire logic stop,
   input wire logic readback,
   output logic out_valid,
   input wire logic out_ready,
   output logic [ADDR_W+N_CH-1:0] out_word,
   output logic capture_done,
   output logic running,
   output logic [ADDR_W-1:0] trig_addr
);
   localparam int unsigned CW = ADDR_W + 1;
   localparam int unsigned DEPTH = 1 << ADDR_W;
   localparam int unsigned NL = lacap_pkg::N_LVL;

   typedef struct packed {
      lacap_pkg::lacap_state_t state;
      logic [ADDR_W-1:0] wptr;
      logic [ADDR_W-1:0] rptr;
      logic [CW-1:0] cnt;
      logic [1:0] level;
      logic [ADDR_W-1:0] taddr;
      logic done;
      logic auto_run;
      logic [lacap_pkg::RATE_W-1:0] div;
      logic [N_CH-1:0] prev;
      logic [1:0] ck_sh;
      logic [N_CH-1:0] pin_s1;
      logic [N_CH-1:0] pin_s2;
      logic ck_s1;
      logic ck_s2;
      logic q_s1;
      logic q_s2;
      logic have_prev;
   } lacap_st_t;

   lacap_st_t st_r;
   lacap_st_t st_nxt;
   logic [N_CH-1:0] mem [DEPTH];
   logic [N_CH-1:0] rd_data;
   logic [NL-1:0] lvl_match;
   logic sample_tick;
   logic store;
   logic fifo_in_ready;
   logic fifo_in_valid;
   logic [CW-1:0] post_cnt;

   // ----------------------------------------------------------------
   // trigger pattern compare, one generate per level and channel
   // ----------------------------------------------------------------
   for (genvar l = 0; l < NL; l++)
   begin : g_lvl
      logic [N_CH-1:0] ok;
      for (genvar c = 0; c < N_CH; c++)
      begin : g_ch
         logic [2:0] cd;
         logic cur;
         logic old;
         assign cd = trig_cond[(l*N_CH+c)*3 +: 3];
         assign cur = st_r.pin_s2[c];
         // edges need a previous sample; the first one never matches
         assign old = st_r.prev[c];
         always_comb
         begin
            case (lacap_pkg::lacap_cond_t'(cd))
               lacap_pkg::LACAP_C_ANY: ok[c] = 1'b1;
               lacap_pkg::LACAP_C_HIGH: ok[c] = cur;
               lacap_pkg::LACAP_C_LOW: ok[c] = !cur;
               lacap_pkg::LACAP_C_RISE: ok[c] = st_r.have_prev && cur && !old;
               lacap_pkg::LACAP_C_FALL: ok[c] = st_r.have_prev && !cur && old;
               lacap_pkg::LACAP_C_EDGE: ok[c] = st_r.have_prev && (cur != old);
               default: ok[c] = 1'b0;
            endcase
         end
      end
      assign lvl_match[l] = &ok;
   end

   // ----------------------------------------------------------------
   // sample tick: external edge or internal divider
   // ----------------------------------------------------------------
   always_comb
   begin
      if (cfg.ext_mode)
         sample_tick = cfg.ext_falling ? (st_r.ck_sh == 2'b10)
                                       : (st_r.ck_sh == 2'b01);
      else
         sample_tick = (st_r.div == cfg.rate_div);
   end
   // qualifier gates every store
   assign store = sample_tick && st_r.q_s2;

   always_comb
   begin
      case (cfg.post)
         lacap_pkg::LACAP_P_STOP: post_cnt = '0;
         lacap_pkg::LACAP_P_FULL: post_cnt = CW'(DEPTH);
         lacap_pkg::LACAP_P_EARLY: post_cnt = CW'(DEPTH * 3 / 4);
         lacap_pkg::LACAP_P_CENTER: post_cnt = CW'(DEPTH / 2);
         lacap_pkg::LACAP_P_LATE: post_cnt = CW'(DEPTH / 4);
         default: post_cnt = '0;
      endcase
   end

   assign fifo_in_valid = (st_r.state == lacap_pkg::LACAP_S_DUMP);
   assign rd_data = mem[st_r.rptr];

   // ----------------------------------------------------------------
   // control state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pin_s1 = probe_in;
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.ck_s1 = external_sample_clock_input;
      st_nxt.ck_s2 = st_r.ck_s1;
      st_nxt.ck_sh = {st_r.ck_sh[0], st_r.ck_s2};
      st_nxt.q_s1 = clock_qualifier;
      st_nxt.q_s2 = st_r.q_s1;
      st_nxt.div = sample_tick ? lacap_pkg::DIV_RST : st_r.div + 1'b1;
      if (store)
      begin
         st_nxt.prev = st_r.pin_s2;
         st_nxt.have_prev = 1'b1;
      end
      case (st_r.state)
         lacap_pkg::LACAP_S_IDLE:
         begin
            if (start)
            begin
               st_nxt.state = lacap_pkg::LACAP_S_ARMED;
               st_nxt.auto_run = cfg.auto_mode;
               st_nxt.done = 1'b0;
               st_nxt.level = 2'b00;
               st_nxt.have_prev = 1'b0;
            end
            else if (readback && st_r.done)
            begin
               st_nxt.state = lacap_pkg::LACAP_S_DUMP;
               st_nxt.rptr = st_r.wptr;
               st_nxt.cnt = CW'(lacap_pkg::CNT_RST);
            end
         end
         lacap_pkg::LACAP_S_ARMED:
         begin
            if (store)
            begin
               st_nxt.wptr = st_r.wptr + 1'b1;
               if (lvl_match[st_r.level])
               begin
                  if (st_r.level == cfg.last_level)
                  begin
                     st_nxt.taddr = st_r.wptr;
                     st_nxt.cnt = CW'(lacap_pkg::CNT_RST);
                     st_nxt.state = (post_cnt == '0) ?
                        lacap_pkg::LACAP_S_DUMP : lacap_pkg::LACAP_S_POST;
                     st_nxt.rptr = st_r.wptr + 1'b1;
                  end
                  else
                     st_nxt.level = st_r.level + 1'b1;
               end
            end
         end
         lacap_pkg::LACAP_S_POST:
         begin
            if (store)
            begin
               st_nxt.wptr = st_r.wptr + 1'b1;
               st_nxt.cnt = st_r.cnt + 1'b1;
               if (st_r.cnt + 1'b1 == post_cnt)
               begin
                  st_nxt.state = lacap_pkg::LACAP_S_DUMP;
                  st_nxt.rptr = st_r.wptr + 1'b1;
                  st_nxt.cnt = CW'(lacap_pkg::CNT_RST);
               end
            end
         end
         lacap_pkg::LACAP_S_DUMP:
         begin
            // dump oldest first; fifo back-pressure stalls the walk
            st_nxt.done = 1'b1;
            if (fifo_in_ready)
            begin
               st_nxt.rptr = st_r.rptr + 1'b1;
               st_nxt.cnt = st_r.cnt + 1'b1;
               if (st_r.cnt == CW'(DEPTH - 1))
                  st_nxt.state = lacap_pkg::LACAP_S_DONE;
            end
         end
         lacap_pkg::LACAP_S_DONE:
         begin
            if (st_r.auto_run)
            begin
               st_nxt.state = lacap_pkg::LACAP_S_ARMED;
               st_nxt.level = 2'b00;
               st_nxt.have_prev = 1'b0;
            end
            else
               st_nxt.state = lacap_pkg::LACAP_S_IDLE;
         end
         default: st_nxt.state = lacap_pkg::LACAP_S_IDLE;
      endcase
      if (stop && st_r.state != lacap_pkg::LACAP_S_DUMP)
      begin
         st_nxt.auto_run = 1'b0;
         if (st_r.state != lacap_pkg::LACAP_S_IDLE)
            st_nxt.state = lacap_pkg::LACAP_S_IDLE;
      end
      else if (stop)
         st_nxt.auto_run = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
         st_r.state <= lacap_pkg::LACAP_S_IDLE;
      end
      else if (ce)
         st_r <= st_nxt;
      if (ce && rst_n && store &&
          (st_r.state == lacap_pkg::LACAP_S_ARMED ||
           st_r.state == lacap_pkg::LACAP_S_POST))
         mem[st_r.wptr] <= st_r.pin_s2;
   end

   lacap_fifo #(
      .WIDTH(ADDR_W + N_CH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({st_r.rptr, rd_data}),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_word)
   );

   assign capture_done = st_r.done;
   assign running = (st_r.state == lacap_pkg::LACAP_S_ARMED) ||
                    (st_r.state == lacap_pkg::LACAP_S_POST);
   assign trig_addr = st_r.taddr;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_ptr_step;
      @(posedge clk) disable iff (!rst_n)
      (ce && store && st_r.state == lacap_pkg::LACAP_S_ARMED) |=>
         st_r.wptr == $past(st_r.wptr) + 1'b1;
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("write pointer did not advance");

   property p_noqual;
      @(posedge clk) disable iff (!rst_n)
      (ce && !st_r.q_s2) |=> st_r.wptr == $past(st_r.wptr);
   endproperty
   a_noqual: assert property (p_noqual)
      else $error("unqualified edge stored");

   property p_idle_hold;
      @(posedge clk) disable iff (!rst_n)
      (st_r.state == lacap_pkg::LACAP_S_IDLE && !start) |=>
         st_r.state != lacap_pkg::LACAP_S_POST;
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("trigger taken while idle");

   property p_taddr;
      @(posedge clk) disable iff (!rst_n)
      (ce && st_r.state == lacap_pkg::LACAP_S_ARMED &&
       st_nxt.state != lacap_pkg::LACAP_S_ARMED && !stop) |=>
         st_r.taddr == $past(st_r.wptr);
   endproperty
   a_taddr: assert property (p_taddr)
      else $error("trigger address not recorded");

   property p_post_len;
      @(posedge clk) disable iff (!rst_n)
      (st_r.state == lacap_pkg::LACAP_S_POST) |-> st_r.cnt < post_cnt;
   endproperty
   a_post_len: assert property (p_post_len)
      else $error("post count overran");

   property p_auto;
      @(posedge clk) disable iff (!rst_n)
      (ce && st_r.state == lacap_pkg::LACAP_S_DONE && st_r.auto_run &&
       !stop) |=> st_r.state == lacap_pkg::LACAP_S_ARMED;
   endproperty
   a_auto: assert property (p_auto)
      else $error("auto mode did not re-arm");

   property p_done;
      @(posedge clk) disable iff (!rst_n)
      (ce && st_r.state == lacap_pkg::LACAP_S_DUMP) |=> capture_done;
   endproperty
   a_done: assert property (p_done)
      else $error("done not raised");

   property p_ext_edge;
      @(posedge clk) disable iff (!rst_n)
      (ce && $past(ce) && $past(ce, 2) && cfg.ext_mode &&
       !cfg.ext_falling && sample_tick) |->
         !$past(st_r.ck_s2, 2) && $past(st_r.ck_s2);
   endproperty
   a_ext_edge: assert property (p_ext_edge)
      else $error("wrong sampling edge");
endmodule : lacap_core
`default_nettype wire

// ### lacap_sut_model.sv
// file: behavioural model of the probed system under test
`timescale 1ns/1ps
`default_nettype none
module lacap_sut_model (
   input wire logic clk,
   input wire logic clr,
   input wire logic ext_run,
   input wire logic ext_fall_sel,
   input wire logic qual_even,
   output logic [lacap_pkg::N_CH-1:0] probe_in,
   output logic ext_clk,
   output logic qual
);
   logic [lacap_pkg::N_CH-1:0] cnt = '0;
   assign probe_in = cnt;
   // odd values gated off, so stored samples step by two
   assign qual = qual_even ? ~cnt[0] : 1'b1;
   // moves just after the block's edge, so clear and hold never race it
   always @(posedge clk)
      if (clr)
         cnt <= '0;
      else if (!ext_run)
         cnt <= cnt + 1'b1;
   // ------------------------------------------------
   // target clock, 800 ns, stands low between frames
   // ------------------------------------------------
   initial
   begin
      ext_clk = 1'b0;
      forever
      begin
         wait (ext_run);
         #37;
         while (ext_run)
         begin
            #400;
            ext_clk = ext_run & ~ext_clk;
            // data moves on the idle edge, settled at the active one
            if (ext_clk == ext_fall_sel)
               cnt = cnt + 1'b1;
         end
         ext_clk = 1'b0;
      end
   end
endmodule : lacap_sut_model
`default_nettype wire

// ### lacap_core_tb_top.sv
// file: self-checking testbench for the capture core
`timescale 1ns/1ps
`default_nettype none
module lacap_core_tb_top;
   // four address bits keep every dump at sixteen words
   localparam int AW = 4;
   localparam int DEP = 16;
   localparam int NC = lacap_pkg::N_CH;
   localparam logic [2:0] HI = lacap_pkg::LACAP_C_HIGH;
   localparam logic [2:0] LO = lacap_pkg::LACAP_C_LOW;
   localparam logic [2:0] RI = lacap_pkg::LACAP_C_RISE;
   localparam logic [2:0] FA = lacap_pkg::LACAP_C_FALL;
   localparam logic [2:0] ED = lacap_pkg::LACAP_C_EDGE;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, start = 1'b0, stop = 1'b0;
   logic readback = 1'b0, out_ready = 1'b0, clr = 1'b0, ext_run = 1'b0;
   logic qual_even = 1'b0;
   logic ext_clk, qual, out_valid, capture_done, running;
   logic [NC-1:0] probe;
   logic [AW+NC-1:0] out_word;
   logic [AW-1:0] trig_addr;
   lacap_pkg::lacap_cfg_t cfg = '0;
   logic [lacap_pkg::N_LVL*NC*3-1:0] tc = '0;
   logic [NC-1:0] wd [DEP];
   logic [NC-1:0] prev [DEP];
   logic [AW-1:0] wa [DEP];
   int pn [5] = '{0, 16, 12, 8, 4};
   int bad_count = 0;
   int samples_checked = 0;

   lacap_core #(.ADDR_W(AW)) dut_u (
      .clk(clk), .rst_n(rst_n), .ce(ce), .probe_in(probe),
      .external_sample_clock_input(ext_clk), .clock_qualifier(qual),
      .cfg(cfg), .trig_cond(tc), .start(start), .stop(stop),
      .readback(readback), .out_valid(out_valid), .out_ready(out_ready),
      .out_word(out_word), .capture_done(capture_done),
      .running(running), .trig_addr(trig_addr)
   );
   lacap_sut_model sut_u (
      .clk(clk), .clr(clr), .ext_run(ext_run),
      .ext_fall_sel(cfg.ext_falling), .qual_even(qual_even),
      .probe_in(probe), .ext_clk(ext_clk), .qual(qual)
   );

   initial forever #50 clk = ~clk;

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic void cond(input int l, input int c, input logic [2:0] k);
      tc[(l*NC+c)*3 +: 3] = k;
   endfunction : cond

   // pops with a gap after each word, so the sink also stalls
   task automatic drain(input int stall);
      int n;
      int g;
      n = 0;
      g = 0;
      while (n < DEP && g < 3000)
      begin
         @(negedge clk);
         g++;
         if (out_ready)
            out_ready = 1'b0;
         else if (out_valid === 1'b1 && g > stall)
         begin
            {wa[n], wd[n]} = out_word;
            n++;
            out_ready = 1'b1;
         end
      end
      @(negedge clk);
      out_ready = 1'b0;
      check("words", n, DEP);
      check("fifo empty", out_valid, 1'b0);
   endtask : drain

   // probe counter restarts with the arm, so sample values are known
   task automatic run_case(input int stall, input int step, input int tv,
                           input int post);
      int g;
      // clear long enough to flush the probe synchronisers with zeros
      @(negedge clk);
      clr = 1'b1;
      repeat (3) @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      start = 1'b0;
      check("running", running, 1'b1);
      ext_run = cfg.ext_mode;
      g = 0;
      while (capture_done !== 1'b1 && g < 3000)
      begin
         @(negedge clk);
         g++;
      end
      ext_run = 1'b0;
      check("done", capture_done, 1'b1);
      drain(stall);
      for (int i = 0; i < DEP; i++)
      begin
         check("addr", wa[i], 4'(trig_addr + post + 1 + i));
         if (i > 0)
            check("step", 18'(wd[i] - wd[i-1]), step);
      end
      if (tv >= 0)
         check("first", wd[0], 18'(tv + (post - 15) * step));
   endtask : run_case

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_idle();
      cond(0, 5, HI);
      cond(0, 0, HI);
      repeat (80) @(negedge clk);
      check("idle run", running, 1'b0);
      check("idle done", capture_done, 1'b0);
   endtask : t_idle

   task automatic t_positions();
      for (int p = 0; p < 5; p++)
      begin
         cfg.post = lacap_pkg::lacap_post_t'(3'(p));
         run_case(p == 0 ? 40 : 0, 1, 33, pn[p]);
      end
   endtask : t_positions

   task automatic t_readback();
      prev = wd;
      readback = 1'b1;
      @(negedge clk);
      readback = 1'b0;
      drain(0);
      for (int i = 0; i < DEP; i++)
         check("readback", wd[i], prev[i]);
   endtask : t_readback

   task automatic t_conds();
      cfg.post = lacap_pkg::LACAP_P_STOP;
      tc = '0;
      cond(0, 5, HI);
      cond(0, 0, LO);
      run_case(0, 1, 32, 0);
      cond(0, 0, RI);
      run_case(0, 1, 33, 0);
      cond(0, 0, 3'h0);
      cond(0, 1, FA);
      cond(0, 2, HI);
      run_case(0, 1, 36, 0);
      cond(0, 2, ED);
      cond(0, 1, LO);
      cond(0, 0, LO);
      run_case(0, 1, 32, 0);
      tc = '0;
      cond(0, 3, HI);
      cond(1, 4, HI);
      cond(2, 4, LO);
      cond(3, 0, HI);
      cfg.last_level = 2'h3;
      run_case(0, 1, 33, 0);
      cfg.last_level = 2'h0;
   endtask : t_conds

   task automatic t_rate();
      tc = '0;
      cond(0, 5, HI);
      // late trigger, so the whole memory holds samples of this run
      cond(0, 6, HI);
      cfg.rate_div = 8'h02;
      run_case(0, 3, -1, 0);
      cfg.rate_div = 8'h00;
      cond(0, 6, 3'h0);
   endtask : t_rate

   task automatic t_ext();
      cfg.ext_mode = 1'b1;
      qual_even = 1'b1;
      for (int e = 0; e < 2; e++)
      begin
         cfg.ext_falling = e[0];
         run_case(0, 2, 32, 0);
      end
      cfg.ext_mode = 1'b0;
      qual_even = 1'b0;
   endtask : t_ext

   task automatic t_auto();
      int g;
      g = 0;
      tc = '0;
      // edge trigger keeps the re-armed capture waiting while we drain
      cond(0, 9, RI);
      cfg.auto_mode = 1'b1;
      run_case(0, 1, 512, 0);
      while (running !== 1'b1 && g < 50)
      begin
         @(negedge clk);
         g++;
      end
      check("rearm", running, 1'b1);
      stop = 1'b1;
      @(negedge clk);
      stop = 1'b0;
      cfg.auto_mode = 1'b0;
      repeat (3) @(negedge clk);
      check("halted", running, 1'b0);
   endtask : t_auto

   initial
   begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_idle();
      t_positions();
      t_readback();
      t_conds();
      t_rate();
      t_ext();
      t_auto();
      wrap_up();
   end

   // whole run needs some two and a half thousand cycles
   initial
   begin
      repeat (30000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule : lacap_core_tb_top
`default_nettype wire
